// ### csr_pkg.sv
package csr_pkg;

    // Register offsets on the plain register port, byte addresses.
    localparam logic [3:0] CSR_OFS_STATUS = 4'h0;
    localparam logic [3:0] CSR_OFS_IRQ_STAT = 4'h4;
    localparam logic [3:0] CSR_OFS_IRQ_CLR = 4'h8;
    localparam logic [3:0] CSR_OFS_IRQ_EN = 4'hC;

    // Field positions in cpu_status_flags.
    localparam int CSR_BIT_ACC_A_OVF = 15;
    localparam int CSR_BIT_ACC_B_OVF = 14;
    localparam int CSR_BIT_ACC_A_CLIP = 13;
    localparam int CSR_BIT_ACC_B_CLIP = 12;
    localparam int CSR_BIT_ANY_OVF = 11;
    localparam int CSR_BIT_ANY_CLIP = 10;
    localparam int CSR_BIT_LOOP = 9;
    localparam int CSR_BIT_HALF_CARRY = 8;
    localparam int CSR_BIT_PRIO = 5;
    localparam int CSR_BIT_REPEAT = 4;
    localparam int CSR_BIT_N = 3;
    localparam int CSR_BIT_OV = 2;
    localparam int CSR_BIT_Z = 1;
    localparam int CSR_BIT_C = 0;

    // Bits taken from neighbouring core registers.
    localparam int CSR_CORE_PRIO_TOP_BIT = 3;
    localparam int CSR_NEST_DIS_BIT = 15;

    // Index of each ALU flag in the ALU update vector.
    localparam int CSR_ALU_C = 0;
    localparam int CSR_ALU_Z = 1;
    localparam int CSR_ALU_OV = 2;
    localparam int CSR_ALU_N = 3;
    localparam int CSR_ALU_HALF_CARRY = 4;

    // Interrupt event positions.
    localparam int CSR_EVT_SAT_A = 0;
    localparam int CSR_EVT_SAT_B = 1;
    localparam int CSR_EVT_ACC_OVF = 2;
    localparam int CSR_EVT_ALU_OV = 3;
    localparam int CSR_EVT_N = 4;

    // Reset values, and the level that blocks user interrupts.
    localparam logic [15:0] CSR_RST_STATUS = 16'h0000;
    localparam logic [3:0] CSR_RST_IRQ = 4'h0;
    localparam logic [2:0] CSR_PRIO_ALL_OFF = 3'h7;

    typedef struct packed {
        logic acc_a_overflow;
        logic acc_b_overflow;
        logic acc_a_clipped_sticky;
        logic acc_b_clipped_sticky;
        logic hw_loop_active;
        logic half_carry_flag;
        logic [2:0] cpu_prio;
        logic repeat_loop_active;
        logic n;
        logic ov;
        logic z;
        logic c;
        logic [CSR_EVT_N-1:0] irq_stat;
        logic [CSR_EVT_N-1:0] irq_en;
        logic [15:0] rdata;
    } csr_state_t;

endpackage

// ### csr_status.sv
`timescale 1ns/10ps
module csr_status (
    // Clock, reset and enable
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    // Neighbouring core registers
    input wire logic [15:0] core_control_reg,
    input wire logic [15:0] interrupt_control_one,
    // Loop sequencer
    input wire logic repeat_busy,
    input wire logic do_loop_busy,
    // Integer ALU flag updates
    input wire logic [csr_pkg::CSR_ALU_HALF_CARRY:0] alu_flag_we,
    input wire logic [csr_pkg::CSR_ALU_HALF_CARRY:0] alu_flag_val,
    // Accumulators
    input wire logic acc_a_ovf_we,
    input wire logic acc_a_ovf,
    input wire logic acc_b_ovf_we,
    input wire logic acc_b_ovf,
    input wire logic acc_a_sat,
    input wire logic acc_b_sat,
    // Interrupt controller priority load
    input wire logic prio_load,
    input wire logic [2:0] prio_val,
    // Status outputs
    output logic [15:0] cpu_status_flags,
    output logic [3:0] cpu_priority_level,
    output logic user_irq_block,
    output logic irq
);
    import csr_pkg::*;

    csr_state_t s;
    csr_state_t next_s;

    logic sel_status;
    logic sel_irq_clr;
    logic sel_irq_en;
    logic wr_status;
    logic wr_irq_clr;
    logic wr_irq_en;

    logic nesting_disable;
    logic prio_top;
    logic any_acc_overflow;
    logic [CSR_EVT_N-1:0] evt;
    logic [15:0] read_word;

    // Status word as software and the core see it.
    function automatic logic [15:0] csr_word(input csr_state_t st);
        logic [15:0] w;
        w = CSR_RST_STATUS;
        w[CSR_BIT_ACC_A_OVF] = st.acc_a_overflow;
        w[CSR_BIT_ACC_B_OVF] = st.acc_b_overflow;
        w[CSR_BIT_ACC_A_CLIP] = st.acc_a_clipped_sticky;
        w[CSR_BIT_ACC_B_CLIP] = st.acc_b_clipped_sticky;
        w[CSR_BIT_ANY_OVF] = st.acc_a_overflow | st.acc_b_overflow;
        w[CSR_BIT_ANY_CLIP] = st.acc_a_clipped_sticky | st.acc_b_clipped_sticky;
        w[CSR_BIT_LOOP] = st.hw_loop_active;
        w[CSR_BIT_HALF_CARRY] = st.half_carry_flag;
        w[CSR_BIT_PRIO +: 3] = st.cpu_prio;
        w[CSR_BIT_REPEAT] = st.repeat_loop_active;
        w[CSR_BIT_N] = st.n;
        w[CSR_BIT_OV] = st.ov;
        w[CSR_BIT_Z] = st.z;
        w[CSR_BIT_C] = st.c;
        return w;
    endfunction

    // Read multiplexer; write-only and unmapped offsets read as zero.
    function automatic logic [15:0] csr_read(
        input logic [3:0] a,
        input csr_state_t st
    );
        logic [15:0] r;
        r = CSR_RST_STATUS;
        unique case (a)
            CSR_OFS_STATUS: begin
                r = csr_word(st);
            end
            CSR_OFS_IRQ_STAT: begin
                r[CSR_EVT_N-1:0] = st.irq_stat;
            end
            CSR_OFS_IRQ_EN: begin
                r[CSR_EVT_N-1:0] = st.irq_en;
            end
            default: begin
                r = CSR_RST_STATUS;
            end
        endcase
        return r;
    endfunction

    // Software write of the status word; the loop flags and the combined bits are not stored.
    // Bit operations on the clip flags can lose a saturation between their read and write,
    // so software is expected to write whole words.
    function automatic csr_state_t sw_status_write(
        input csr_state_t st,
        input logic [15:0] d,
        input logic lock
    );
        csr_state_t r;
        r = st;
        r.acc_a_overflow = d[CSR_BIT_ACC_A_OVF];
        r.acc_b_overflow = d[CSR_BIT_ACC_B_OVF];
        if (d[CSR_BIT_ANY_CLIP]) begin
            r.acc_a_clipped_sticky = d[CSR_BIT_ACC_A_CLIP];
            r.acc_b_clipped_sticky = d[CSR_BIT_ACC_B_CLIP];
        end else begin
            r.acc_a_clipped_sticky = 1'b0;
            r.acc_b_clipped_sticky = 1'b0;
        end
        r.half_carry_flag = d[CSR_BIT_HALF_CARRY];
        if (!lock) begin
            r.cpu_prio = d[CSR_BIT_PRIO +: 3];
        end
        r.n = d[CSR_BIT_N];
        r.ov = d[CSR_BIT_OV];
        r.z = d[CSR_BIT_Z];
        r.c = d[CSR_BIT_C];
        return r;
    endfunction

    // ALU flag merge; a flag whose strobe is low keeps its value.
    function automatic csr_state_t alu_update(
        input csr_state_t st,
        input logic [CSR_ALU_HALF_CARRY:0] we,
        input logic [CSR_ALU_HALF_CARRY:0] v
    );
        csr_state_t r;
        r = st;
        if (we[CSR_ALU_N]) begin
            r.n = v[CSR_ALU_N];
        end
        if (we[CSR_ALU_OV]) begin
            r.ov = v[CSR_ALU_OV];
        end
        // The ALU judges zero across a multi-word operation, so the flag follows its value.
        if (we[CSR_ALU_Z]) begin
            r.z = v[CSR_ALU_Z];
        end
        if (we[CSR_ALU_C]) begin
            r.c = v[CSR_ALU_C];
        end
        if (we[CSR_ALU_HALF_CARRY]) begin
            r.half_carry_flag = v[CSR_ALU_HALF_CARRY];
        end
        return r;
    endfunction

    assign sel_status = addr == CSR_OFS_STATUS;
    assign sel_irq_clr = addr == CSR_OFS_IRQ_CLR;
    assign sel_irq_en = addr == CSR_OFS_IRQ_EN;
    assign wr_status = wr && sel_status;
    assign wr_irq_clr = wr && sel_irq_clr;
    assign wr_irq_en = wr && sel_irq_en;

    assign nesting_disable = interrupt_control_one[CSR_NEST_DIS_BIT];
    assign prio_top = core_control_reg[CSR_CORE_PRIO_TOP_BIT];
    assign any_acc_overflow = s.acc_a_overflow | s.acc_b_overflow;
    assign read_word = csr_read(addr, s);

    always_comb begin
        next_s = s;
        evt = '0;
        if (ce) begin
            // Software goes first so that a hardware update in the same cycle wins.
            if (wr_status) begin
                next_s = sw_status_write(next_s, wdata, nesting_disable);
            end

            // The interrupt controller may move the level while software is locked out.
            if (prio_load) begin
                next_s.cpu_prio = prio_val;
            end

            if (acc_a_ovf_we) begin
                next_s.acc_a_overflow = acc_a_ovf;
            end
            if (acc_b_ovf_we) begin
                next_s.acc_b_overflow = acc_b_ovf;
            end

            // A saturation in the cycle of a clearing write is kept, so no clip goes unseen.
            if (acc_a_sat) begin
                next_s.acc_a_clipped_sticky = 1'b1;
            end
            if (acc_b_sat) begin
                next_s.acc_b_clipped_sticky = 1'b1;
            end

            next_s = alu_update(next_s, alu_flag_we, alu_flag_val);

            // Loop flags mirror the sequencer and ignore software.
            next_s.repeat_loop_active = repeat_busy;
            next_s.hw_loop_active = do_loop_busy;

            evt[CSR_EVT_SAT_A] = acc_a_sat;
            evt[CSR_EVT_SAT_B] = acc_b_sat;
            evt[CSR_EVT_ACC_OVF] = (next_s.acc_a_overflow | next_s.acc_b_overflow)
                & ~any_acc_overflow;
            evt[CSR_EVT_ALU_OV] = alu_flag_we[CSR_ALU_OV] & alu_flag_val[CSR_ALU_OV];

            if (wr_irq_clr) begin
                next_s.irq_stat = s.irq_stat & ~wdata[CSR_EVT_N-1:0];
            end
            if (wr_irq_en) begin
                next_s.irq_en = wdata[CSR_EVT_N-1:0];
            end
            // Set after clear: an event in the clearing cycle survives.
            next_s.irq_stat = next_s.irq_stat | evt;

            // Read data stand for one cycle only and are zero otherwise.
            if (rd) begin
                next_s.rdata = read_word;
            end else begin
                next_s.rdata = CSR_RST_STATUS;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rdata = s.rdata;
    assign cpu_status_flags = csr_word(s);
    // The top bit lives in the core control register, so it is never stored here.
    assign cpu_priority_level = {prio_top, s.cpu_prio};
    assign user_irq_block = prio_top
        | (s.cpu_prio == CSR_PRIO_ALL_OFF);
    assign irq = |(s.irq_stat & s.irq_en);

endmodule

// ### csr_assertions.sv
`timescale 1ns/10ps
module csr_assertions import csr_pkg::*; (
    // Clock and register port
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    // Core inputs
    input wire logic repeat_busy,
    input wire logic do_loop_busy,
    input wire logic acc_a_sat,
    input wire logic acc_b_sat,
    input wire logic prio_load,
    input wire logic [15:0] core_control_reg,
    input wire logic [15:0] interrupt_control_one,
    // Status outputs
    input wire logic [15:0] cpu_status_flags,
    input wire logic [3:0] cpu_priority_level,
    input wire logic user_irq_block
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic sw;
    assign sw = ce && wr && addr == CSR_OFS_STATUS;
    a_prio_level: assert property (
        cpu_priority_level == {core_control_reg[3], cpu_status_flags[7:5]}) else $error("bad level");
    a_user_block: assert property (
        user_irq_block == (core_control_reg[3] || cpu_status_flags[7:5] == 3'h7))
        else $error("bad user block");
    a_comb_or: assert property (
        cpu_status_flags[11] == |cpu_status_flags[15:14]
        && cpu_status_flags[10] == |cpu_status_flags[13:12]) else $error("bad combined bit");
    a_repeat_flag: assert property (
        ce |=> cpu_status_flags[4] == $past(repeat_busy)) else $error("bad repeat flag");
    a_loop_flag: assert property (
        ce |=> cpu_status_flags[9] == $past(do_loop_busy)) else $error("bad loop flag");
    a_sat_set: assert property (
        ce && acc_a_sat |=> cpu_status_flags[13]) else $error("clip flag not set");
    a_sat_set_b: assert property (
        ce && acc_b_sat |=> cpu_status_flags[12]) else $error("clip flag b not set");
    a_sat_hold: assert property (
        ce && cpu_status_flags[13] && !sw |=> cpu_status_flags[13]) else $error("clip flag lost");
    a_clip_clear: assert property (
        sw && !wdata[CSR_BIT_ANY_CLIP] && !acc_a_sat && !acc_b_sat
        |=> cpu_status_flags[13:12] == 2'h0)
        else $error("clip flags not cleared");
    a_clip_write: assert property (
        sw && wdata[CSR_BIT_ANY_CLIP] && !acc_a_sat |=> cpu_status_flags[13] == $past(wdata[13]))
        else $error("clip flag not written");
    a_prio_lock: assert property (
        sw && interrupt_control_one[15] && !prio_load |=> $stable(cpu_status_flags[7:5]))
        else $error("locked level changed");
    c_locked_write: cover property (sw && interrupt_control_one[15]);
    c_clip: cover property (ce && acc_a_sat);
    c_frozen: cover property (!ce && acc_b_sat);
    c_level_seven: cover property (user_irq_block && !core_control_reg[3]);
endmodule

// ### csr_alu_model.sv
`timescale 1ns/10ps
module csr_alu_model import csr_pkg::*; (
    // Request
    input wire logic clk,
    input wire logic go,
    input wire logic [15:0] op_a,
    input wire logic [15:0] op_b,
    // Flag updates
    output logic [CSR_ALU_HALF_CARRY:0] alu_flag_we = 5'h00,
    output logic [CSR_ALU_HALF_CARRY:0] alu_flag_val = 5'h00
);
    logic [16:0] sum;
    logic [8:0] low;
    assign sum = {1'b0, op_a} + {1'b0, op_b};
    assign low = {1'b0, op_a[7:0]} + {1'b0, op_b[7:0]};
    // Word add only; every flag is updated together, as a real add does.
    always @(posedge clk) begin
        alu_flag_we <= {5{go}};
        alu_flag_val[CSR_ALU_C] <= sum[16];
        alu_flag_val[CSR_ALU_Z] <= sum[15:0] == 16'h0000;
        alu_flag_val[CSR_ALU_OV] <= op_a[15] == op_b[15] && sum[15] != op_a[15];
        alu_flag_val[CSR_ALU_N] <= sum[15];
        alu_flag_val[CSR_ALU_HALF_CARRY] <= low[8];
    end
endmodule

// ### testbench.sv
`timescale 1ns/10ps
module testbench;
    import csr_pkg::*;
    logic clk = 0, reset_n = 0, ce = 1, wr = 0, rd = 0, go = 0, rep = 0, dol = 0, blk, irq;
    logic [3:0] addr = 4'h0, lvl;
    logic [15:0] wdata = 16'h0000, ccr = 16'h0000, ic1 = 16'h0000, rdata, flags;
    logic [15:0] op_a = 16'h0000, op_b = 16'h0000;
    logic [6:0] hw = 7'h00;
    logic [2:0] prio_val = 3'h0;
    logic [4:0] we, val;
    int err_count = 0, n_tests = 0, cyc = 0;
    initial forever #20 clk = ~clk;
    csr_alu_model csr_alu_model_i (.clk(clk), .go(go), .op_a(op_a), .op_b(op_b),
        .alu_flag_we(we), .alu_flag_val(val));
    csr_status csr_status_i (.clk(clk), .reset_n(reset_n), .ce(ce), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .core_control_reg(ccr),
        .interrupt_control_one(ic1), .repeat_busy(rep), .do_loop_busy(dol),
        .alu_flag_we(we), .alu_flag_val(val), .acc_a_ovf_we(hw[6]), .acc_a_ovf(hw[5]),
        .acc_b_ovf_we(hw[4]), .acc_b_ovf(hw[3]), .acc_a_sat(hw[2]), .acc_b_sat(hw[1]),
        .prio_load(hw[0]), .prio_val(prio_val), .cpu_status_flags(flags),
        .cpu_priority_level(lvl), .user_irq_block(blk), .irq(irq));
    task automatic chk(string n, logic [15:0] e, logic [15:0] s);
        n_tests++;
        if (s !== e) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wreg(logic [3:0] a, logic [15:0] d);
        @(posedge clk);
        wr <= 1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 0;
        #1;
    endtask
    task automatic rreg(logic [3:0] a, logic [15:0] e);
        @(posedge clk);
        rd <= 1;
        addr <= a;
        @(posedge clk);
        rd <= 0;
        #1 chk("rdata", e, rdata);
    endtask
    task automatic pulse(logic [6:0] v, logic [2:0] p);
        @(posedge clk);
        hw <= v;
        prio_val <= p;
        @(posedge clk);
        hw <= 7'h00;
        #1;
    endtask
    task automatic alu(logic [15:0] a, logic [15:0] b);
        @(posedge clk);
        go <= 1;
        op_a <= a;
        op_b <= b;
        @(posedge clk);
        go <= 0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // A hang is cut short well beyond the hundred-odd cycles the tests need.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        reset_n <= 1;
        rreg(CSR_OFS_STATUS, CSR_RST_STATUS);
        rreg(CSR_OFS_IRQ_STAT, 16'h0000);
        $display("test reset done");
        alu(16'h7FFF, 16'h0001);
        chk("flags", 16'h010C, flags);
        alu(16'hFFFF, 16'h0001);
        chk("flags", 16'h0103, flags);
        alu(16'h0001, 16'h0001);
        chk("flags", 16'h0000, flags);
        $display("test alu done");
        pulse(7'h04, 3'h0);
        chk("flags", 16'h2400, flags);
        wreg(CSR_OFS_STATUS, 16'h0400);
        chk("flags", 16'h0000, flags);
        pulse(7'h02, 3'h0);
        chk("flags", 16'h1400, flags);
        wreg(CSR_OFS_STATUS, 16'h2400);
        chk("flags", 16'h2400, flags);
        wreg(CSR_OFS_STATUS, 16'h3000);
        chk("flags", 16'h0000, flags);
        pulse(7'h60, 3'h0);
        chk("flags", 16'h8800, flags);
        $display("test clip done");
        rreg(CSR_OFS_IRQ_STAT, 16'h000F);
        chk("irq", 16'h0000, {15'h0, irq});
        wreg(CSR_OFS_IRQ_EN, 16'h0004);
        chk("irq", 16'h0001, {15'h0, irq});
        wreg(CSR_OFS_IRQ_CLR, 16'h000F);
        chk("irq", 16'h0000, {15'h0, irq});
        rreg(CSR_OFS_IRQ_CLR, 16'h0000);
        rreg(4'h2, 16'h0000);
        $display("test irq done");
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            ccr <= {12'h000, i[3], 3'h0};
            wreg(CSR_OFS_STATUS, {8'h00, i[2:0], 5'h00});
            chk("level", {12'h000, i[3:0]}, {12'h000, lvl});
            chk("block", {15'h0, i[3] | (i[2:0] == 3'h7)}, {15'h0, blk});
        end
        @(posedge clk);
        ic1 <= 16'h8000;
        wreg(CSR_OFS_STATUS, 16'h0040);
        chk("flags", 16'h00E0, flags);
        pulse(7'h01, 3'h5);
        chk("flags", 16'h00A0, flags);
        $display("test level done");
        @(posedge clk);
        ic1 <= 16'h0000;
        rep <= 1;
        dol <= 1;
        wreg(CSR_OFS_STATUS, 16'h0000);
        chk("flags", 16'h0210, flags);
        @(posedge clk);
        rep <= 0;
        dol <= 0;
        wreg(CSR_OFS_STATUS, 16'h0210);
        chk("flags", 16'h0000, flags);
        $display("test loop done");
        // A saturation in the cycle of a clearing write must survive.
        @(posedge clk);
        hw <= 7'h04;
        wr <= 1;
        addr <= CSR_OFS_STATUS;
        wdata <= 16'h0000;
        @(posedge clk);
        hw <= 7'h00;
        wr <= 0;
        #1 chk("flags", 16'h2400, flags);
        // With the clock enable low every strobe is ignored.
        @(posedge clk);
        ce <= 0;
        pulse(7'h18, 3'h0);
        wreg(CSR_OFS_STATUS, 16'h0000);
        chk("flags", 16'h2400, flags);
        @(posedge clk);
        ce <= 1;
        pulse(7'h18, 3'h0);
        chk("flags", 16'h6C00, flags);
        $display("test enable done");
        tally_and_finish();
    end
endmodule
bind csr_status csr_assertions csr_assertions_i (.*);
